// ---- core/rrp_pkg.sv ----
package rrp_pkg;

    // data memory address and data widths
    localparam int unsigned RRP_AW = 12;
    localparam int unsigned RRP_DW = 8;

    // instruction word: [15:10] opcode, [9] destination select, [8] access select, [7:0] file address
    localparam logic [5:0]  RRP_OPC_ROTR    = 6'h10;
    localparam int unsigned RRP_OPC_MSB     = 15;
    localparam int unsigned RRP_OPC_LSB     = 10;
    localparam int unsigned RRP_OP_D_BIT    = 9;
    localparam int unsigned RRP_OP_A_BIT    = 8;
    localparam int unsigned RRP_OP_F_MSB    = 7;
    localparam int unsigned RRP_OP_W        = 16;

    // access bank: low file addresses sit in page 0, the rest in the top page
    localparam logic [7:0]  RRP_ACCESS_SPLIT = 8'h60;
    localparam logic [7:0]  RRP_INDEXED_MAX  = 8'h5f;
    localparam logic [3:0]  RRP_PAGE_LO      = 4'h0;
    localparam logic [3:0]  RRP_PAGE_HI      = 4'hf;

    // register byte offsets on the bus
    localparam logic [7:0]  RRP_OFF_OPCODE  = 8'h00;
    localparam logic [7:0]  RRP_OFF_BANK    = 8'h04;
    localparam logic [7:0]  RRP_OFF_CONFIG  = 8'h08;
    localparam logic [7:0]  RRP_OFF_INDEX   = 8'h0c;
    localparam logic [7:0]  RRP_OFF_ACC     = 8'h10;
    localparam logic [7:0]  RRP_OFF_STATUS  = 8'h14;

    // field positions
    localparam int unsigned RRP_CFG_EXT_BIT = 0;
    localparam int unsigned RRP_ST_BUSY_BIT = 0;
    localparam int unsigned RRP_ST_ZERO_BIT = 1;
    localparam int unsigned RRP_ST_NEG_BIT  = 2;
    localparam int unsigned RRP_ST_BAD_BIT  = 3;
    localparam int unsigned RRP_BANK_W      = 4;

    typedef enum logic [2:0]
    {
        RRP_IDLE    = 3'h0,
        RRP_DECODE  = 3'h1,
        RRP_READ    = 3'h3,
        RRP_PROCESS = 3'h2,
        RRP_WRITE   = 3'h6
    } rrp_state_e;

    typedef enum logic [2:0]
    {
        RRP_R_OPCODE,
        RRP_R_BANK,
        RRP_R_CONFIG,
        RRP_R_INDEX,
        RRP_R_ACC,
        RRP_R_STATUS,
        RRP_R_NONE
    } rrp_reg_e;

    typedef struct packed
    {
        rrp_state_e              st;
        logic [RRP_OP_W-1:0]     op;
        logic [RRP_BANK_W-1:0]   bank;
        logic                    ext_en;
        logic [RRP_AW-1:0]       index;
        logic [RRP_DW-1:0]       acc;
        logic                    neg;
        logic                    zero;
        logic                    bad_op;
        logic [RRP_AW-1:0]       addr;
        logic [RRP_DW-1:0]       opnd;
        logic                    rd_en;
        logic                    wr_en;
        logic [RRP_DW-1:0]       wdata;
        logic [31:0]             prdata;
        logic                    pready;
        logic                    pslverr;
        logic                    busy;
    } rrp_state_s;

    localparam rrp_state_s RRP_RESET = '0;

endpackage : rrp_pkg

// ---- core/rrp_alu_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface rrp_alu_if;
    import rrp_pkg::*;
    logic [RRP_DW-1:0] opnd;   // operand read from the file register
    logic [RRP_DW-1:0] res;    // rotated result
    logic              neg;    // result sign
    logic              zero;   // result is zero

    modport core (output opnd, input res, input neg, input zero);
    modport unit (input opnd, output res, output neg, output zero);
endinterface : rrp_alu_if
`default_nettype wire

// ---- core/rrp_rot_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
module rrp_rot_unit
(
    rrp_alu_if.unit alu    // operand in, result and flags out
);
    import rrp_pkg::*;

    // bit 0 wraps to bit 7, carry neither read nor written
    assign alu.res  = {alu.opnd[0], alu.opnd[RRP_DW-1:1]};
    assign alu.neg  = alu.res[RRP_DW-1];
    assign alu.zero = (alu.res == '0);
endmodule : rrp_rot_unit
`default_nettype wire

// ---- core/rrp_exec.sv ----
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rrp_exec
(
    input  wire logic                      pclk,       // core clock
    input  wire logic                      presetn,    // async reset, active low
    input  wire logic                      ce,         // clock enable, freezes all state when low
    input  wire logic                      psel,       // apb select
    input  wire logic                      penable,    // apb access phase
    input  wire logic                      pwrite,     // apb direction
    input  wire logic [7:0]                paddr,      // apb byte address
    input  wire logic [31:0]               pwdata,     // apb write data
    output logic      [31:0]               prdata,     // apb read data
    output logic                           pready,     // apb ready
    output logic                           pslverr,    // apb error
    output logic      [rrp_pkg::RRP_AW-1:0] mem_addr,  // data memory address
    output logic                           mem_rd_en,  // read strobe, data back next cycle
    input  wire logic [rrp_pkg::RRP_DW-1:0] mem_rdata, // data memory read data
    output logic                           mem_wr_en,  // write strobe
    output logic      [rrp_pkg::RRP_DW-1:0] mem_wdata, // data memory write data
    output logic      [rrp_pkg::RRP_DW-1:0] acc_out,   // accumulator
    output logic                           flag_neg,   // sign flag
    output logic                           flag_zero,  // zero flag
    output logic                           busy        // instruction in flight
);
    import rrp_pkg::*;

    rrp_state_s s_reg;
    rrp_state_s s_next;
    rrp_alu_if  alu ();

    rrp_rot_unit u_rot
    (
        .alu (alu.unit)
    );

    // the rotate unit sees only the captured operand, never the live memory bus
    assign alu.opnd = s_reg.opnd;

    function automatic rrp_reg_e reg_sel(input logic [7:0] a);
        rrp_reg_e r;
        r = RRP_R_NONE;
        unique case (a)
            RRP_OFF_OPCODE: r = RRP_R_OPCODE;
            RRP_OFF_BANK:   r = RRP_R_BANK;
            RRP_OFF_CONFIG: r = RRP_R_CONFIG;
            RRP_OFF_INDEX:  r = RRP_R_INDEX;
            RRP_OFF_ACC:    r = RRP_R_ACC;
            RRP_OFF_STATUS: r = RRP_R_STATUS;
            default:        r = RRP_R_NONE;
        endcase
        return r;
    endfunction : reg_sel

    // read mux: narrow registers sit in the low bits, the rest reads as zero
    function automatic logic [31:0] read_word(input rrp_reg_e r, input rrp_state_s s);
        logic [31:0] w;
        w = '0;
        unique case (r)
            RRP_R_OPCODE: w[RRP_OP_W-1:0]    = s.op;
            RRP_R_BANK:   w[RRP_BANK_W-1:0]  = s.bank;
            RRP_R_CONFIG: w[RRP_CFG_EXT_BIT] = s.ext_en;
            RRP_R_INDEX:  w[RRP_AW-1:0]      = s.index;
            RRP_R_ACC:    w[RRP_DW-1:0]      = s.acc;
            RRP_R_STATUS:
            begin
                w[RRP_ST_BUSY_BIT] = s.busy;
                w[RRP_ST_ZERO_BIT] = s.zero;
                w[RRP_ST_NEG_BIT]  = s.neg;
                w[RRP_ST_BAD_BIT]  = s.bad_op;
            end
            RRP_R_NONE:   w = '0;
        endcase
        return w;
    endfunction : read_word

    function automatic logic op_is_rotr(input logic [RRP_OP_W-1:0] w);
        return w[RRP_OPC_MSB:RRP_OPC_LSB] == RRP_OPC_ROTR;
    endfunction : op_is_rotr

    // operand address from the opcode fields
    function automatic logic [RRP_AW-1:0] form_addr(input logic [RRP_OP_W-1:0] w,
                                                    input logic [RRP_BANK_W-1:0] bank,
                                                    input logic ext_en,
                                                    input logic [RRP_AW-1:0] index);
        logic [7:0] f;
        f = w[RRP_OP_F_MSB:0];
        if (w[RRP_OP_A_BIT])
            return {bank, f};
        // indexed offset wraps within the 12-bit data space
        else if (ext_en && (f <= RRP_INDEXED_MAX))
            return index + {RRP_PAGE_LO, f};
        else if (f < RRP_ACCESS_SPLIT)
            return {RRP_PAGE_LO, f};
        else
            return {RRP_PAGE_HI, f};
    endfunction : form_addr

    logic     acc_phase;
    logic     commit;
    logic     opc_wr;
    rrp_reg_e sel;

    // pready is a one-cycle pulse, so the second access cycle is the completing one
    assign acc_phase = psel && penable;
    assign commit    = acc_phase && s_reg.pready;
    assign sel       = reg_sel(paddr);
    assign opc_wr    = pwrite && (sel == RRP_R_OPCODE);

    always_comb
    begin
        s_next = s_reg;

        // bus: one wait state, then the transfer completes with pready
        s_next.pready  = 1'b0;
        s_next.pslverr = 1'b0;
        if (acc_phase && !s_reg.pready)
        begin
            s_next.pready = 1'b1;
            // answer formed in the wait state so prdata and pslverr leave flops
            s_next.prdata = read_word(sel, s_reg);
            if (sel == RRP_R_NONE)
                s_next.pslverr = 1'b1;
            // a new instruction is refused while one is in flight or if it is not ours
            if (opc_wr && (s_reg.st != RRP_IDLE || !op_is_rotr(pwdata[RRP_OP_W-1:0])))
                s_next.pslverr = 1'b1;
        end

        // writes take effect at the completing edge only
        if (commit && pwrite && !s_reg.pslverr)
        begin
            unique case (sel)
                RRP_R_OPCODE:
                begin
                    s_next.op = pwdata[RRP_OP_W-1:0];
                    s_next.st = RRP_DECODE;
                end
                RRP_R_BANK:   s_next.bank = pwdata[RRP_BANK_W-1:0];
                RRP_R_CONFIG: s_next.ext_en = pwdata[RRP_CFG_EXT_BIT];
                RRP_R_INDEX:  s_next.index = pwdata[RRP_AW-1:0];
                RRP_R_ACC:    s_next.acc = pwdata[RRP_DW-1:0];
                RRP_R_STATUS:
                    if (pwdata[RRP_ST_BAD_BIT])
                        s_next.bad_op = 1'b0;
                RRP_R_NONE:   ;
            endcase
        end
        // a refused opcode is remembered; no clear can race it on the same bus
        if (commit && opc_wr && s_reg.pslverr)
            s_next.bad_op = 1'b1;

        // four phases: decode, read, process, write
        s_next.rd_en = 1'b0;
        s_next.wr_en = 1'b0;
        unique case (s_reg.st)
            RRP_IDLE:    ;
            RRP_DECODE:
            begin
                // address is formed once and stands through the write phase
                s_next.addr  = form_addr(s_reg.op, s_reg.bank, s_reg.ext_en, s_reg.index);
                s_next.rd_en = 1'b1;
                s_next.st    = RRP_READ;
            end
            // memory answers the cycle after the strobe; nothing to do here
            RRP_READ:    s_next.st = RRP_PROCESS;
            RRP_PROCESS:
            begin
                s_next.opnd = mem_rdata;
                s_next.st   = RRP_WRITE;
            end
            RRP_WRITE:
            begin
                if (s_reg.op[RRP_OP_D_BIT])
                begin
                    s_next.wr_en = 1'b1;
                    s_next.wdata = alu.res;
                end
                else
                    s_next.acc = alu.res;
                // flags follow every result, whichever destination takes it
                s_next.neg  = alu.neg;
                s_next.zero = alu.zero;
                s_next.st   = RRP_IDLE;
            end
            // unused codes drop back to idle instead of locking the core
            default:     s_next.st = RRP_IDLE;
        endcase

        // busy is a flop of its own so the pin shows no decode glitch
        s_next.busy = (s_next.st != RRP_IDLE);
    end

    // a low clock enable holds every flop, bus handshake included
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            // idle, strobes low, flags clear
            s_reg <= RRP_RESET;
        else if (ce)
            s_reg <= s_next;
    end

    assign prdata    = s_reg.prdata;
    assign pready    = s_reg.pready;
    assign pslverr   = s_reg.pslverr;
    assign mem_addr  = s_reg.addr;
    assign mem_rd_en = s_reg.rd_en;
    assign mem_wr_en = s_reg.wr_en;
    assign mem_wdata = s_reg.wdata;
    assign acc_out   = s_reg.acc;
    assign flag_neg  = s_reg.neg;
    assign flag_zero = s_reg.zero;
    assign busy      = s_reg.busy;
endmodule : rrp_exec
`default_nettype wire

// ---- bench/rrp_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module rrp_mem_model
(
    input  wire logic                       pclk,      // clock
    input  wire logic [rrp_pkg::RRP_AW-1:0] mem_addr,  // address
    input  wire logic                       mem_rd_en, // read strobe
    output logic      [rrp_pkg::RRP_DW-1:0] mem_rdata, // read data
    input  wire logic                       mem_wr_en, // write strobe
    input  wire logic [rrp_pkg::RRP_DW-1:0] mem_wdata  // write data
);
    import rrp_pkg::*;
    logic [RRP_DW-1:0] mem [0:(1<<RRP_AW)-1];
    logic [RRP_AW-1:0] last_raddr;
    always @(posedge pclk)
    begin
        // data valid one cycle only; toggling otherwise exposes a late sample
        mem_rdata <= mem_rd_en ? mem[mem_addr] : ~mem_rdata;
        if (mem_rd_en)
            last_raddr <= mem_addr;
        if (mem_wr_en)
            mem[mem_addr] <= mem_wdata;
    end
endmodule : rrp_mem_model
`default_nettype wire

// ---- bench/rrp_exec_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module rrp_exec_chk
(
    input wire logic                       pclk,      // clock
    input wire logic                       presetn,   // reset
    input wire logic                       psel,      // select
    input wire logic                       pwrite,    // direction
    input wire logic [7:0]                 paddr,     // address
    input wire logic                       pready,    // ready
    input wire logic                       pslverr,   // error
    input wire logic [rrp_pkg::RRP_AW-1:0] mem_addr,  // address
    input wire logic                       mem_rd_en, // read
    input wire logic [rrp_pkg::RRP_DW-1:0] mem_rdata, // read data
    input wire logic                       mem_wr_en, // write
    input wire logic [rrp_pkg::RRP_DW-1:0] mem_wdata, // write data
    input wire logic [rrp_pkg::RRP_DW-1:0] acc_out,   // accumulator
    input wire logic                       flag_neg,  // sign
    input wire logic                       flag_zero, // zero
    input wire logic                       busy       // in flight
);
    import rrp_pkg::*;
    logic       rd_d1_reg;
    logic [7:0] opnd_reg;
    logic [7:0] rot;
    assign rot = {opnd_reg[0], opnd_reg[7:1]};
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rd_d1_reg <= 1'b0;
            opnd_reg  <= 8'h00;
        end
        else
        begin
            rd_d1_reg <= mem_rd_en;
            if (rd_d1_reg)
                opnd_reg <= mem_rdata;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_opc_taken;
        psel && pready && pwrite && !pslverr && paddr == RRP_OFF_OPCODE;
    endsequence
    sequence s_exec;
        busy ##1 mem_rd_en;
    endsequence
    AST_LAUNCH: assert property (s_opc_taken |=> s_exec)
        else $error("opcode write did not start execution");
    AST_WR_AFTER_RD: assert property (mem_wr_en |-> $past(mem_rd_en, 3))
        else $error("write phase out of order");
    AST_WDATA: assert property (mem_wr_en |-> mem_wdata == rot)
        else $error("write data not rotated operand");
    AST_WR_ADDR: assert property (mem_wr_en |-> mem_addr == $past(mem_addr, 3))
        else $error("write back to other register");
    AST_FLAGS: assert property ($fell(busy) |-> flag_neg == rot[7] && flag_zero == (rot == 8'h00))
        else $error("flags wrong");
    AST_ACC_DEST: assert property ($fell(busy) && !mem_wr_en |-> acc_out == rot)
        else $error("accumulator not loaded");
    AST_ACC_ONLY: assert property ($changed(acc_out) |-> $fell(busy) || $past(pready && pwrite && paddr == RRP_OFF_ACC))
        else $error("accumulator changed without cause");
    AST_PSLV: assert property (pslverr |-> pready)
        else $error("error without ready");
endmodule : rrp_exec_chk
bind rrp_exec rrp_exec_chk rrp_exec_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .pwrite(pwrite),
    .paddr(paddr), .pready(pready), .pslverr(pslverr), .mem_addr(mem_addr), .mem_rd_en(mem_rd_en),
    .mem_rdata(mem_rdata), .mem_wr_en(mem_wr_en), .mem_wdata(mem_wdata), .acc_out(acc_out),
    .flag_neg(flag_neg), .flag_zero(flag_zero), .busy(busy));
`default_nettype wire

// ---- bench/rrp_exec_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module rrp_exec_tb_top;
    import rrp_pkg::*;
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, mem_rd_en, mem_wr_en, flag_neg, flag_zero;
    logic busy, err_v;
    logic [7:0] paddr, mem_rdata, mem_wdata, acc_out;
    logic [31:0] pwdata, prdata, rd_v;
    logic [11:0] mem_addr;
    int fail_count = 0;
    int compares = 0;
    rrp_exec rrp_exec_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mem_addr(mem_addr), .mem_rd_en(mem_rd_en), .mem_rdata(mem_rdata), .mem_wr_en(mem_wr_en),
        .mem_wdata(mem_wdata), .acc_out(acc_out), .flag_neg(flag_neg), .flag_zero(flag_zero), .busy(busy));
    rrp_mem_model rrp_mem_model_i (.pclk(pclk), .mem_addr(mem_addr), .mem_rd_en(mem_rd_en),
        .mem_rdata(mem_rdata), .mem_wr_en(mem_wr_en), .mem_wdata(mem_wdata));
    always #2 pclk = ~pclk;
    task automatic final_report;
        $display("compares %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : final_report
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
            fail_count++;
        end
    endtask : chk
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd_v = prdata;
        err_v = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic run_case(input logic d, input logic a, input logic ext, input logic [3:0] bank,
        input logic [7:0] f, input logic [11:0] idx, input logic [7:0] v, input logic [11:0] ea);
        logic [7:0] rot;
        int n;
        rot = {v[0], v[7:1]};
        rrp_mem_model_i.mem[ea] = v;
        apb(RRP_OFF_BANK, 1'b1, 32'(bank));
        apb(RRP_OFF_CONFIG, 1'b1, 32'(ext));
        apb(RRP_OFF_INDEX, 1'b1, 32'(idx));
        apb(RRP_OFF_ACC, 1'b1, 32'h0000005a);
        apb(RRP_OFF_OPCODE, 1'b1, 32'({RRP_OPC_ROTR, d, a, f}));
        apb(RRP_OFF_OPCODE, 1'b1, 32'h00004000);
        chk("refused while busy", 32'h1, 32'(err_v));
        n = 0;
        while (busy !== 1'b0 && n < 20)
        begin
            @(posedge pclk);
            n++;
        end
        chk("instruction finished", 32'h0, 32'(busy));
        // the write-back lands at the edge after busy drops; look one edge later
        @(posedge pclk);
        chk("operand address", 32'(ea), 32'(rrp_mem_model_i.last_raddr));
        chk("file register", 32'(d ? rot : v), 32'(rrp_mem_model_i.mem[ea]));
        chk("accumulator", 32'(d ? 8'h5a : rot), 32'(acc_out));
        chk("flags", 32'({rot[7], rot == 8'h00}), 32'({flag_neg, flag_zero}));
        $display("case done, address %h", ea);
    endtask : run_case
    initial
    begin
        repeat (3000) @(posedge pclk);
        fail_count++;
        final_report();
    end
    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(RRP_OFF_STATUS, 1'b0, 32'h0);
        chk("status at reset", 32'h0, rd_v);
        apb(8'h18, 1'b0, 32'h0);
        chk("unmapped read", 32'h1, {rd_v[30:0], err_v});
        $display("reset and decode tests done");
        run_case(1'b1, 1'b0, 1'b0, 4'h5, 8'h20, 12'h000, 8'hd7, 12'h020);
        run_case(1'b0, 1'b0, 1'b0, 4'h5, 8'h20, 12'h000, 8'hd7, 12'h020);
        run_case(1'b1, 1'b1, 1'b0, 4'h5, 8'h33, 12'h000, 8'h01, 12'h533);
        run_case(1'b0, 1'b0, 1'b0, 4'h5, 8'h80, 12'h000, 8'h00, 12'hf80);
        run_case(1'b1, 1'b0, 1'b1, 4'h5, 8'h5f, 12'h123, 8'h02, 12'h182);
        run_case(1'b0, 1'b0, 1'b1, 4'h5, 8'h60, 12'h123, 8'h80, 12'hf60);
        run_case(1'b1, 1'b1, 1'b1, 4'h2, 8'h10, 12'h123, 8'h10, 12'h210);
        // freeze an instruction in its read phase; it must resume where it stopped
        apb(RRP_OFF_OPCODE, 1'b1, 32'({RRP_OPC_ROTR, 1'b0, 1'b1, 8'h10}));
        ce <= 1'b0;
        repeat (4) @(posedge pclk);
        chk("frozen busy", 32'h1, 32'(busy));
        ce <= 1'b1;
        repeat (6) @(posedge pclk);
        chk("resumed accumulator", 32'h04, 32'(acc_out));
        apb(RRP_OFF_ACC, 1'b0, 32'h0);
        chk("accumulator readback", 32'h04, rd_v);
        apb(RRP_OFF_STATUS, 1'b1, 32'h00000008);
        apb(RRP_OFF_OPCODE, 1'b1, 32'h00008000);
        chk("foreign opcode", 32'h1, 32'(err_v));
        apb(RRP_OFF_STATUS, 1'b0, 32'h0);
        chk("status after refusal", 32'h8, rd_v);
        apb(RRP_OFF_STATUS, 1'b1, 32'h00000008);
        apb(RRP_OFF_STATUS, 1'b0, 32'h0);
        chk("error cleared", 32'h0, 32'(rd_v[3]));
        $display("freeze and status tests done");
        final_report();
    end
endmodule : rrp_exec_tb_top
`default_nettype wire
